// ==== design/ppmcr_regs.v ====
// power management and message interrupt capability register bank
//
// Behaviour
// - power management id byte reads 01h
// - next pointer resets 8Ch, host read-only
// - power management revision reads 011b
// - PME clock, B2/B3, bus control read zero
// - device specific init bit defaults zero
// - auxiliary current field defaults 111b
// - D1 and D2 support default one
// - PME support field defaults 11111b
// - power state field encodes D0..D3hot, resets D0
// - D3 to D0 write gives hot reset
// - skip-reset bit default one, else internal reset
// - PME messages only while PME enable set
// - PME status write-one-clear, function 2 zero
// - message interrupt id byte reads 05h
// - message enable writable, no functional effect
// - message next pointer resets E0h
// - loadable defaults via loader, host cannot write
`timescale 1ns/1ps
`include "ppmcr_consts.vh"

module ppmcr_regs #(
    parameter FUNC_NUM = 0
) (
    input  wire        I_SYS_CLK,
    input  wire        I_ARST_N,
    // configuration access from the link
    input  wire        I_CFG_WR,
    input  wire        I_CFG_RD,
    input  wire [7:0]  I_CFG_ADDR,
    input  wire [3:0]  I_CFG_BE,
    input  wire [31:0] I_CFG_WDATA,
    output wire        O_CFG_HIT,
    output wire [31:0] O_CFG_RDATA,
    output wire        O_CFG_RVALID,
    // default loader (serial management port or eeprom)
    input  wire        I_LOAD_WR,
    input  wire [7:0]  I_LOAD_ADDR,
    input  wire [31:0] I_LOAD_DATA,
    // power management side
    input  wire        I_PME_EVENT,
    output wire [1:0]  O_POWER_STATE,
    output wire        O_PME_ENABLE,
    output wire        O_PME_MSG,
    output wire        O_HOT_RESET,
    output wire        O_INTERNAL_RESET
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire [7:0] cfg_dw_addr;
    wire       sel_pm_cap;
    wire       sel_pm_csr;
    wire       sel_msg_cap;
    wire       sel_msg_addr;
    wire       sel_msg_data;
    wire [7:0] ld_dw_addr;

    assign cfg_dw_addr  = {I_CFG_ADDR[7:2], 2'b00};
    assign sel_pm_cap   = (cfg_dw_addr == `PPMCR_OFS_PM_CAP);
    assign sel_pm_csr   = (cfg_dw_addr == `PPMCR_OFS_PM_CSR);
    assign sel_msg_cap  = (cfg_dw_addr == `PPMCR_OFS_MSG_CAP);
    assign sel_msg_addr = (cfg_dw_addr == `PPMCR_OFS_MSG_ADDR);
    assign sel_msg_data = (cfg_dw_addr == `PPMCR_OFS_MSG_DATA);
    assign O_CFG_HIT    = sel_pm_cap | sel_pm_csr | sel_msg_cap | sel_msg_addr | sel_msg_data;
    assign ld_dw_addr   = {I_LOAD_ADDR[7:2], 2'b00};

    // ------------------------------------------------------------
    // loadable defaults
    // ------------------------------------------------------------
    wire [31:0] pm_cap_ld;
    wire [0:0]  skip_reset_ld;
    wire [7:0]  msg_next_ld;

    ppmcr_ldreg #(
        .W    (32),
        .RST  (`PPMCR_PM_CAP_RST),
        .MASK (`PPMCR_PM_CAP_LD_MASK)
    ) u_pm_cap_ld (
        .I_SYS_CLK (I_SYS_CLK),
        .I_ARST_N  (I_ARST_N),
        .i_load    (I_LOAD_WR && (ld_dw_addr == `PPMCR_OFS_PM_CAP)),
        .i_data    (I_LOAD_DATA),
        .o_value   (pm_cap_ld)
    );

    ppmcr_ldreg #(
        .W    (1),
        .RST  (`PPMCR_NSR_RST),
        .MASK (1'h1)
    ) u_skip_reset_ld (
        .I_SYS_CLK (I_SYS_CLK),
        .I_ARST_N  (I_ARST_N),
        .i_load    (I_LOAD_WR && (ld_dw_addr == `PPMCR_OFS_PM_CSR)),
        .i_data    (I_LOAD_DATA[`PPMCR_NSR_BIT]),
        .o_value   (skip_reset_ld)
    );

    ppmcr_ldreg #(
        .W    (8),
        .RST  (`PPMCR_MSG_NXT_RST),
        .MASK (8'hff)
    ) u_msg_next_ld (
        .I_SYS_CLK (I_SYS_CLK),
        .I_ARST_N  (I_ARST_N),
        .i_load    (I_LOAD_WR && (ld_dw_addr == `PPMCR_OFS_MSG_CAP)),
        .i_data    (I_LOAD_DATA[`PPMCR_NXT_MSB:`PPMCR_NXT_LSB]),
        .o_value   (msg_next_ld)
    );

    // ------------------------------------------------------------
    // capability word as seen by the host
    // ------------------------------------------------------------
    reg [31:0] pm_cap_view;

    always @* begin
        pm_cap_view = pm_cap_ld;
        pm_cap_view[`PPMCR_PM_ID_MSB:`PPMCR_PM_ID_LSB] = `PPMCR_PM_CAP_ID;
        pm_cap_view[`PPMCR_PM_REV_MSB:`PPMCR_PM_REV_LSB] = `PPMCR_PM_REV;
        pm_cap_view[`PPMCR_PM_CLK_BIT] = 1'b0;
        // reserved bit stays zero
        pm_cap_view[`PPMCR_PM_RSVD20_BIT] = 1'b0;
    end

    // ------------------------------------------------------------
    // control/status registers
    // ------------------------------------------------------------
    reg  [1:0]  power_state_q;
    reg  [1:0]  power_state_d;
    reg         pme_en_q;
    reg         pme_en_d;
    reg  [3:0]  data_sel_q;
    reg  [3:0]  data_sel_d;
    reg         pme_sts_q;
    reg         pme_sts_d;
    reg         hot_rst_q;
    reg         hot_rst_d;
    reg         int_rst_q;
    reg         int_rst_d;
    reg         pme_msg_q;
    reg         pme_msg_d;
    wire        csr_wr;
    wire        d3_to_d0;

    assign csr_wr   = I_CFG_WR && sel_pm_csr;
    assign d3_to_d0 = csr_wr && I_CFG_BE[0] && (power_state_q == `PPMCR_PS_D3HOT)
                      && (I_CFG_WDATA[`PPMCR_PS_MSB:`PPMCR_PS_LSB] == `PPMCR_PS_D0);

    always @* begin
        power_state_d = power_state_q;
        pme_en_d      = pme_en_q;
        data_sel_d    = data_sel_q;
        pme_sts_d     = pme_sts_q;
        if (csr_wr && I_CFG_BE[0]) begin
            power_state_d = I_CFG_WDATA[`PPMCR_PS_MSB:`PPMCR_PS_LSB];
        end
        if (csr_wr && I_CFG_BE[1]) begin
            pme_en_d   = I_CFG_WDATA[`PPMCR_PME_EN_BIT];
            data_sel_d = I_CFG_WDATA[`PPMCR_DSEL_MSB:`PPMCR_DSEL_LSB];
            if (I_CFG_WDATA[`PPMCR_PME_STS_BIT]) begin
                pme_sts_d = 1'b0;
            end
        end
        if (I_PME_EVENT) begin
            pme_sts_d = 1'b1;
        end
        if (FUNC_NUM == 2) begin
            pme_sts_d = 1'b0;
        end
    end

    always @* begin
        hot_rst_d = d3_to_d0;
        int_rst_d = d3_to_d0 && !skip_reset_ld[0];
        pme_msg_d = I_PME_EVENT && pme_en_q;
    end

    always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            power_state_q <= `PPMCR_PS_D0;
            pme_en_q      <= 1'b0;
            data_sel_q    <= 4'h0;
            pme_sts_q     <= 1'b0;
            hot_rst_q     <= 1'b0;
            int_rst_q     <= 1'b0;
            pme_msg_q     <= 1'b0;
        end else begin
            power_state_q <= power_state_d;
            pme_en_q      <= pme_en_d;
            data_sel_q    <= data_sel_d;
            pme_sts_q     <= pme_sts_d;
            hot_rst_q     <= hot_rst_d;
            int_rst_q     <= int_rst_d;
            pme_msg_q     <= pme_msg_d;
        end
    end

    assign O_POWER_STATE    = power_state_q;
    assign O_PME_ENABLE     = pme_en_q;
    assign O_PME_MSG        = pme_msg_q;
    assign O_HOT_RESET      = hot_rst_q;
    assign O_INTERNAL_RESET = int_rst_q;

    // ------------------------------------------------------------
    // message interrupt registers (storage only)
    // ------------------------------------------------------------
    reg         msg_en_q;
    reg         msg_en_d;
    reg  [2:0]  mme_q;
    reg  [2:0]  mme_d;
    reg  [29:0] msg_addr_q;
    reg  [29:0] msg_addr_d;
    reg  [15:0] msg_data_q;
    reg  [15:0] msg_data_d;
    wire        msg_cap_wr;
    wire        msg_addr_wr;
    wire        msg_data_wr;
    wire [31:0] addr_full;

    assign msg_cap_wr  = I_CFG_WR && sel_msg_cap;
    assign msg_addr_wr = I_CFG_WR && sel_msg_addr;
    assign msg_data_wr = I_CFG_WR && sel_msg_data;
    assign addr_full   = {msg_addr_q, 2'b00};

    always @* begin
        msg_en_d   = msg_en_q;
        mme_d      = mme_q;
        msg_addr_d = msg_addr_q;
        msg_data_d = msg_data_q;
        if (msg_cap_wr && I_CFG_BE[2]) begin
            msg_en_d = I_CFG_WDATA[`PPMCR_MSG_EN_BIT];
            mme_d    = I_CFG_WDATA[`PPMCR_MME_MSB:`PPMCR_MME_LSB];
        end
        if (msg_addr_wr) begin
            msg_addr_d = {
                I_CFG_BE[3] ? I_CFG_WDATA[31:24] : addr_full[31:24],
                I_CFG_BE[2] ? I_CFG_WDATA[23:16] : addr_full[23:16],
                I_CFG_BE[1] ? I_CFG_WDATA[15:8]  : addr_full[15:8],
                I_CFG_BE[0] ? I_CFG_WDATA[7:2]   : addr_full[7:2]
            };
        end
        if (msg_data_wr) begin
            msg_data_d = {
                I_CFG_BE[1] ? I_CFG_WDATA[15:8] : msg_data_q[15:8],
                I_CFG_BE[0] ? I_CFG_WDATA[7:0]  : msg_data_q[7:0]
            };
        end
    end

    always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            msg_en_q   <= 1'b0;
            mme_q      <= 3'h0;
            msg_addr_q <= `PPMCR_MSG_ADDR_RST;
            msg_data_q <= `PPMCR_MSG_DATA_RST;
        end else begin
            msg_en_q   <= msg_en_d;
            mme_q      <= mme_d;
            msg_addr_q <= msg_addr_d;
            msg_data_q <= msg_data_d;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    reg  [31:0] rd_mux;
    reg  [31:0] rdata_q;
    reg         rvalid_q;

    always @* begin
        // unmapped reads return zero
        rd_mux = 32'h00000000;
        if (sel_pm_cap) begin
            rd_mux = pm_cap_view;
        end else if (sel_pm_csr) begin
            rd_mux[`PPMCR_PS_MSB:`PPMCR_PS_LSB]     = power_state_q;
            rd_mux[`PPMCR_NSR_BIT]                  = skip_reset_ld[0];
            rd_mux[`PPMCR_PME_EN_BIT]               = pme_en_q;
            rd_mux[`PPMCR_DSEL_MSB:`PPMCR_DSEL_LSB] = data_sel_q;
            rd_mux[`PPMCR_PME_STS_BIT]              = pme_sts_q;
            rd_mux[`PPMCR_B2B3_BIT]                 = 1'b0;
            rd_mux[`PPMCR_BPCC_BIT]                 = 1'b0;
            // no data sources behind the select
            rd_mux[`PPMCR_PM_DATA_MSB:`PPMCR_PM_DATA_LSB] = `PPMCR_PM_DATA_RST;
        end else if (sel_msg_cap) begin
            rd_mux[`PPMCR_PM_ID_MSB:`PPMCR_PM_ID_LSB] = `PPMCR_MSG_CAP_ID;
            rd_mux[`PPMCR_NXT_MSB:`PPMCR_NXT_LSB]     = msg_next_ld;
            rd_mux[`PPMCR_MSG_EN_BIT]                 = msg_en_q;
            rd_mux[`PPMCR_MMC_MSB:`PPMCR_MMC_LSB]     = 3'h0;
            rd_mux[`PPMCR_MSG64_BIT]                  = 1'b0;
            rd_mux[`PPMCR_MME_MSB:`PPMCR_MME_LSB]     = mme_q;
        end else if (sel_msg_addr) begin
            rd_mux = addr_full;
        end else if (sel_msg_data) begin
            rd_mux[15:0] = msg_data_q;
        end
    end

    always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            rdata_q  <= 32'h00000000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= I_CFG_RD;
            if (I_CFG_RD) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign O_CFG_RDATA  = rdata_q;
    assign O_CFG_RVALID = rvalid_q;

endmodule

// ==== inc/ppmcr_consts.vh ====
// constants for the power management and message interrupt capability registers
`ifndef PPMCR_CONSTS_VH
`define PPMCR_CONSTS_VH

// ------------------------------------------------------------
// register offsets (configuration byte addresses)
// ------------------------------------------------------------
`define PPMCR_OFS_PM_CAP        8'h80
`define PPMCR_OFS_PM_CSR        8'h84
`define PPMCR_OFS_MSG_CAP       8'h8c
`define PPMCR_OFS_MSG_ADDR      8'h90
`define PPMCR_OFS_MSG_DATA      8'h94

// ------------------------------------------------------------
// capability dword at 0x80
// ------------------------------------------------------------
`define PPMCR_PM_CAP_ID         8'h01
`define PPMCR_PM_REV            3'h3
`define PPMCR_PM_CAP_RST        32'hffc38c01
`define PPMCR_PM_CAP_LD_MASK    32'hffe0ff00
`define PPMCR_PM_ID_LSB         0
`define PPMCR_PM_ID_MSB         7
`define PPMCR_PM_REV_LSB        16
`define PPMCR_PM_REV_MSB        18
`define PPMCR_PM_CLK_BIT        19
`define PPMCR_PM_RSVD20_BIT     20

// ------------------------------------------------------------
// control/status dword at 0x84
// ------------------------------------------------------------
`define PPMCR_PS_LSB            0
`define PPMCR_PS_MSB            1
`define PPMCR_NSR_BIT           3
`define PPMCR_NSR_RST           1'h1
`define PPMCR_PME_EN_BIT        8
`define PPMCR_DSEL_LSB          9
`define PPMCR_DSEL_MSB          12
`define PPMCR_PME_STS_BIT       15
`define PPMCR_PM_DATA_RST       8'h00
`define PPMCR_B2B3_BIT          22
`define PPMCR_BPCC_BIT          23
`define PPMCR_PM_DATA_LSB       24
`define PPMCR_PM_DATA_MSB       31
`define PPMCR_PS_D0             2'h0
`define PPMCR_PS_D1             2'h1
`define PPMCR_PS_D2             2'h2
`define PPMCR_PS_D3HOT          2'h3

// ------------------------------------------------------------
// message interrupt capability at 0x8c..0x94
// ------------------------------------------------------------
`define PPMCR_MSG_CAP_ID        8'h05
`define PPMCR_MSG_NXT_RST       8'he0
`define PPMCR_NXT_LSB           8
`define PPMCR_NXT_MSB           15
`define PPMCR_MSG_EN_BIT        16
`define PPMCR_MME_LSB           20
`define PPMCR_MME_MSB           22
`define PPMCR_MMC_LSB           17
`define PPMCR_MMC_MSB           19
`define PPMCR_MSG64_BIT         23
`define PPMCR_MSG_ADDR_RST      30'h00000000
`define PPMCR_MSG_DATA_RST      16'h0000

`endif

// ==== design/ppmcr_ldreg.v ====
// loadable read-only default register with per-bit load mask
`timescale 1ns/1ps

module ppmcr_ldreg #(
    parameter           W    = 8,
    parameter [W-1:0]   RST  = {W{1'b0}},
    parameter [W-1:0]   MASK = {W{1'b1}}
) (
    input  wire         I_SYS_CLK,
    input  wire         I_ARST_N,
    input  wire         i_load,
    input  wire [W-1:0] i_data,
    output wire [W-1:0] o_value
);

    reg  [W-1:0] value_q;
    wire [W-1:0] value_d;

    // only masked bits take the loader's value
    assign value_d = i_load ? ((i_data & MASK) | (value_q & ~MASK)) : value_q;

    always @(posedge I_SYS_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            value_q <= RST;
        end else begin
            value_q <= value_d;
        end
    end

    assign o_value = value_q;

endmodule

// ==== sim/ppmcr_regs_monitor.sv ====
// assertion checker for the capability register bank
`timescale 1ns/1ps
module ppmcr_regs_monitor (
    input wire        I_SYS_CLK,
    input wire        I_ARST_N,
    input wire        I_CFG_WR,
    input wire        I_CFG_RD,
    input wire [7:0]  I_CFG_ADDR,
    input wire [3:0]  I_CFG_BE,
    input wire [31:0] I_CFG_WDATA,
    input wire [31:0] O_CFG_RDATA,
    input wire        I_PME_EVENT,
    input wire [1:0]  O_POWER_STATE,
    input wire        O_PME_ENABLE,
    input wire        O_PME_MSG,
    input wire        O_HOT_RESET,
    input wire        O_INTERNAL_RESET
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_ARST_N);
    wire [5:0]  dw    = I_CFG_ADDR[7:2];
    wire [31:0] rq    = O_CFG_RDATA;
    wire        rd80  = I_CFG_RD && dw == 6'h20;
    wire        rd84  = I_CFG_RD && dw == 6'h21;
    wire        rd8c  = I_CFG_RD && dw == 6'h23;
    wire        ps_wr = I_CFG_WR && dw == 6'h21 && I_CFG_BE[0];
    // ----
    // read-back fields
    // ----
    pm_id_a: assert property (rd80 |=> rq[7:0] == 8'h01)
        else $error("pm id wrong");
    pm_rev_a: assert property (rd80 |=> rq[20:16] == 5'h03)
        else $error("pm revision or clock bit wrong");
    bridge_zero_a: assert property (rd84 |=> rq[23:22] == 2'h0 && rq[2] == 1'b0)
        else $error("hardwired bits not zero");
    msg_id_a: assert property (rd8c |=> rq[7:0] == 8'h05 && rq[19:17] == 3'h0 && !rq[23])
        else $error("message id or capable wrong");
    addr_low_a: assert property (I_CFG_RD && dw == 6'h24 |=> rq[1:0] == 2'h0)
        else $error("address low bits not zero");
    // ----
    // power state and events
    // ----
    ps_write_a: assert property (ps_wr |=> O_POWER_STATE == $past(I_CFG_WDATA[1:0]))
        else $error("power state not written");
    pme_send_a: assert property (I_PME_EVENT && O_PME_ENABLE |=> O_PME_MSG)
        else $error("pme message missing");
    pme_gate_a: assert property (O_PME_MSG |-> $past(I_PME_EVENT && O_PME_ENABLE))
        else $error("pme message without enable");
    hot_rst_a: assert property (ps_wr && I_CFG_WDATA[1:0] == 2'h0 && O_POWER_STATE == 2'h3
        |=> O_HOT_RESET ##1 !O_HOT_RESET)
        else $error("hot reset pulse wrong");
    hot_only_a: assert property (O_HOT_RESET |-> $past(O_POWER_STATE) == 2'h3)
        else $error("hot reset from wrong state");
    int_rst_a: assert property (O_INTERNAL_RESET |-> O_HOT_RESET)
        else $error("internal reset without hot reset");
    hot_c: cover property (O_HOT_RESET);
    int_c: cover property (O_INTERNAL_RESET);
    pme_c: cover property (O_PME_MSG);
endmodule
bind ppmcr_regs ppmcr_regs_monitor u_mon (.I_SYS_CLK(I_SYS_CLK), .I_ARST_N(I_ARST_N),
    .I_CFG_WR(I_CFG_WR), .I_CFG_RD(I_CFG_RD), .I_CFG_ADDR(I_CFG_ADDR), .I_CFG_BE(I_CFG_BE),
    .I_CFG_WDATA(I_CFG_WDATA), .O_CFG_RDATA(O_CFG_RDATA), .I_PME_EVENT(I_PME_EVENT),
    .O_POWER_STATE(O_POWER_STATE), .O_PME_ENABLE(O_PME_ENABLE), .O_PME_MSG(O_PME_MSG),
    .O_HOT_RESET(O_HOT_RESET), .O_INTERNAL_RESET(O_INTERNAL_RESET));

// ==== sim/ppmcr_host.sv ====
// configuration host model issuing register accesses
`timescale 1ns/1ps
module ppmcr_host (
    input  wire        i_clk,
    input  wire [31:0] i_rdata,
    output reg         o_wr    = 1'b0,
    output reg         o_rd    = 1'b0,
    output reg  [7:0]  o_addr  = 8'h00,
    output reg  [3:0]  o_be    = 4'h0,
    output reg  [31:0] o_wdata = 32'h0
);
    // released lines show the inverse of the last value
    task cfg_wr(input [7:0] a, input [3:0] b, input [31:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_be <= b;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_be <= ~b;
        o_wdata <= ~d;
    endtask
    task cfg_rd(input [7:0] a, output [31:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask
endmodule

// ==== sim/testbench.sv ====
// self-checking bench for the capability register bank
`timescale 1ns/1ps
module testbench;
    reg         clk     = 1'b0;
    reg         rst_n   = 1'b0;
    reg         pme     = 1'b0;
    reg         ld_wr   = 1'b0;
    reg  [7:0]  ld_addr = 8'h00;
    reg  [31:0] ld_data = 32'h0;
    reg  [31:0] v;
    wire        wr, rd, hit, rvalid, pmsg, pen, hrst, irst;
    wire [7:0]  addr;
    wire [3:0]  be;
    wire [1:0]  ps;
    wire [31:0] wdata, rdata, rdata2;
    integer     err_count = 0;
    integer     checks    = 0;
    always #20 clk = ~clk;
    ppmcr_host host (.i_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_be(be), .o_wdata(wdata));
    ppmcr_regs dut (.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_CFG_WR(wr), .I_CFG_RD(rd),
        .I_CFG_ADDR(addr), .I_CFG_BE(be), .I_CFG_WDATA(wdata), .O_CFG_HIT(hit),
        .O_CFG_RDATA(rdata), .O_CFG_RVALID(rvalid), .I_LOAD_WR(ld_wr), .I_LOAD_ADDR(ld_addr),
        .I_LOAD_DATA(ld_data), .I_PME_EVENT(pme), .O_POWER_STATE(ps), .O_PME_ENABLE(pen),
        .O_PME_MSG(pmsg), .O_HOT_RESET(hrst), .O_INTERNAL_RESET(irst));
    ppmcr_regs #(.FUNC_NUM(2)) dut_f2 (.I_SYS_CLK(clk), .I_ARST_N(rst_n), .I_CFG_WR(wr),
        .I_CFG_RD(rd), .I_CFG_ADDR(addr), .I_CFG_BE(be), .I_CFG_WDATA(wdata), .O_CFG_HIT(),
        .O_CFG_RDATA(rdata2), .O_CFG_RVALID(), .I_LOAD_WR(ld_wr), .I_LOAD_ADDR(ld_addr),
        .I_LOAD_DATA(ld_data), .I_PME_EVENT(pme), .O_POWER_STATE(), .O_PME_ENABLE(),
        .O_PME_MSG(), .O_HOT_RESET(), .O_INTERNAL_RESET());
    // ----
    // helpers
    // ----
    task check(input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task rdchk(input [7:0] a, input [31:0] e);
        reg h;
        h = a == 8'h80 || a == 8'h84 || a == 8'h8c || a == 8'h90 || a == 8'h94;
        fork
            host.cfg_rd(a, v);
            begin
                @(posedge clk);
                #1;
                check(hit, h);
            end
        join
        check(v, e);
        check(rvalid, 1'b1);
    endtask
    task ld(input [7:0] a, input [31:0] d);
        @(posedge clk);
        ld_wr <= 1'b1;
        ld_addr <= a;
        ld_data <= d;
        @(posedge clk);
        ld_wr <= 1'b0;
    endtask
    task pulse_pme;
        @(posedge clk);
        pme <= 1'b1;
        @(posedge clk);
        pme <= 1'b0;
        #1;
    endtask
    // ----
    // scenarios
    // ----
    task t_reset;
        rdchk(8'h80, 32'hffc38c01);
        rdchk(8'h84, 32'h00000008);
        rdchk(8'h8c, 32'h0000e005);
        rdchk(8'h90, 32'h0);
        rdchk(8'h94, 32'h0);
        rdchk(8'h98, 32'h0);
    endtask
    task t_host_ro;
        host.cfg_wr(8'h80, 4'hf, 32'h0);
        rdchk(8'h80, 32'hffc38c01);
        host.cfg_wr(8'h8c, 4'hf, 32'hffffffff);
        rdchk(8'h8c, 32'h0071e005);
        host.cfg_wr(8'h8c, 4'hf, 32'h0);
        host.cfg_wr(8'h90, 4'hf, 32'hffffffff);
        host.cfg_wr(8'h90, 4'h1, 32'h0);
        rdchk(8'h90, 32'hffffff00);
        host.cfg_wr(8'h94, 4'hf, 32'hffffffff);
        rdchk(8'h94, 32'h0000ffff);
    endtask
    task t_power(input exp_int);
        integer s;
        for (s = 0; s < 4; s = s + 1) begin
            host.cfg_wr(8'h84, 4'h1, s);
            rdchk(8'h84, {28'h0, ~exp_int, 1'b0, s[1:0]});
        end
        host.cfg_wr(8'h84, 4'h1, 32'h0);
        #1;
        check(hrst, 1'b1);
        check(irst, exp_int);
        check(ps, 2'h0);
        host.cfg_wr(8'h84, 4'h1, 32'h3);
        host.cfg_wr(8'h84, 4'h2, 32'h0);
        #1;
        check(hrst, 1'b0);
        check(ps, 2'h3);
        host.cfg_wr(8'h84, 4'hf, 32'hffff7ef7);
        rdchk(8'h84, {19'h0, 4'hf, 5'h0, ~exp_int, 3'h3});
        host.cfg_wr(8'h84, 4'hf, 32'h0);
    endtask
    task t_load;
        ld(8'h80, 32'hffffffff);
        rdchk(8'h80, 32'hffe3ff01);
        ld(8'h8c, 32'h0);
        rdchk(8'h8c, 32'h00000005);
        ld(8'h84, 32'h0);
        rdchk(8'h84, 32'h0);
    endtask
    task t_pme;
        pulse_pme;
        check(pmsg, 1'b0);
        check(pen, 1'b0);
        rdchk(8'h84, 32'h00008000);
        check(rdata2[15], 1'b0);
        host.cfg_wr(8'h84, 4'h2, 32'h00008100);
        rdchk(8'h84, 32'h00000100);
        check(pen, 1'b1);
        pulse_pme;
        check(pmsg, 1'b1);
    endtask
    task complete_run;
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_host_ro;
        t_power(1'b0);
        t_load;
        t_power(1'b1);
        t_pme;
        complete_run;
    end
    initial begin
        #100000;
        err_count = err_count + 1;
        complete_run;
    end
endmodule
